// [rtl/sce_pkg.sv]
// Constants and carrier types for the host command executor of the SAR controller.
// Assumes one 125 MHz core clock and a synchronous, active-high reset.

package sce_pkg;

  // ----------------------------------------------------------------------
  // Command word layout
  // ----------------------------------------------------------------------
  localparam int OP_HI    = 29;
  localparam int OP_LO    = 26;
  localparam int SEL_BIT  = 25;
  localparam int IDX_HI   = 18;
  localparam int IDX_LO   = 4;
  localparam int POOL_HI  = 20;
  localparam int POOL_LO  = 16;
  localparam int CNT_HI   = 15;
  localparam int CNT_LO   = 0;
  localparam int BUSY_BIT = 31;

  localparam int IDX_W  = IDX_HI - IDX_LO + 1;
  localparam int POOL_W = POOL_HI - POOL_LO + 1;
  localparam int CNT_W  = CNT_HI - CNT_LO + 1;

  localparam logic [3:0] OP_OPEN    = 4'h8;
  localparam logic [3:0] OP_CLOSE   = 4'h9;
  localparam logic [3:0] OP_DEACT   = 4'hA;
  localparam logic [3:0] OP_TX_KICK = 4'hC;
  localparam logic [3:0] OP_REFILL  = 4'hD;
  localparam logic [3:0] OP_DELAY   = 4'hF;

  // ----------------------------------------------------------------------
  // Sizes, counts and reset values
  // ----------------------------------------------------------------------
  localparam int CMD_QUEUE_DEPTH = 10;
  localparam int EXT_QUEUE_DEPTH = 10;
  localparam int NUM_POOLS       = 32;
  localparam int DELAY_CYCLES    = 36;
  localparam int NUM_TABLES_DEF  = 64;

  localparam logic [3:0]  RX_DEACT_STATUS = 4'h1;
  localparam logic [31:0] CMD_WORD_RESET  = 32'h0000_0000;
  localparam logic [31:0] EXT_WORD_RESET  = 32'h0000_0000;

  typedef enum logic [1:0] {
    SCE_ST_INIT = 2'b00,
    SCE_ST_RUN  = 2'b01
  } sce_state_t;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        cmd_wr;
    logic        cmd_rd;
    logic        ext_wr;
    logic        ext_rd;
    logic [31:0] wdata;
  } sce_host_req_t;

  typedef struct packed {
    logic        rvalid;
    logic [31:0] rdata;
    logic        cmd_full;
    logic        ext_full;
  } sce_host_rsp_t;

  typedef struct packed {
    logic             valid;
    logic [IDX_W-1:0] idx;
  } sce_chan_evt_t;

  typedef struct packed {
    logic             valid;
    logic [IDX_W-1:0] idx;
    logic [3:0]       status;
  } sce_rx_post_t;

endpackage

// [rtl/sce_queue.sv]
// Small first-in first-out queue for host command and extension words.
// Assumes push and pop handshakes on the same clock; no bypass path.
`timescale 1ns/1ps
`default_nettype none

module sce_queue #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 10
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             push_valid,
  output var  logic             push_ready,
  input  wire logic [WIDTH-1:0] push_data,
  output var  logic             pop_valid,
  input  wire logic             pop_ready,
  output var  logic [WIDTH-1:0] pop_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
  } sce_queue_state_t;

  sce_queue_state_t state_reg;
  sce_queue_state_t state_next;
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic             do_push;
  logic             do_pop;

  assign push_ready = (state_reg.count != CW'(DEPTH));
  assign pop_valid  = (state_reg.count != '0);
  assign pop_data   = mem[state_reg.rd_ptr];
  assign do_push    = push_valid && push_ready;
  assign do_pop     = pop_valid && pop_ready;

  always_comb begin
    state_next = state_reg;
    if (do_push) begin
      state_next.wr_ptr = (state_reg.wr_ptr == AW'(DEPTH - 1)) ? '0 : state_reg.wr_ptr + 1'b1;
    end
    if (do_pop) begin
      state_next.rd_ptr = (state_reg.rd_ptr == AW'(DEPTH - 1)) ? '0 : state_reg.rd_ptr + 1'b1;
    end
    if (do_push && !do_pop) begin
      state_next.count = state_reg.count + 1'b1;
    end else if (do_pop && !do_push) begin
      state_next.count = state_reg.count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
    if (do_push) begin
      mem[state_reg.wr_ptr] <= push_data;
    end
  end

endmodule

`default_nettype wire

// [rtl/sce_delay_timer.sv]
// Hold-off timer: busy for a fixed number of cycles after a start pulse.
// Assumes start is a one-cycle pulse; a start while busy restarts the count.
`timescale 1ns/1ps
`default_nettype none

module sce_delay_timer #(
  parameter int CYCLES = 36
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic start,
  output var  logic busy
);
  localparam int CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] remain;
  } sce_timer_state_t;

  sce_timer_state_t state_reg;
  sce_timer_state_t state_next;

  assign busy = (state_reg.remain != '0);

  always_comb begin
    state_next = state_reg;
    if (start) begin
      state_next.remain = CW'(CYCLES);
    end else if (busy) begin
      state_next.remain = state_reg.remain - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule

`default_nettype wire

// [rtl/sce_command_executor.sv]
// Host command executor: queues host command and extension words, then runs
// open, close, deactivate, transmit kick, buffer refill and delay commands.
// Assumes the transmit engine reports descriptor-end events on tx_done and
// that receive mailbox and transmit logic consume one-cycle event pulses.
`timescale 1ns/1ps
`default_nettype none

module sce_command_executor
  import sce_pkg::*;
#(
  parameter int NUM_TABLES = sce_pkg::NUM_TABLES_DEF
) (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire sce_pkg::sce_host_req_t host_req,
  output var  sce_pkg::sce_host_rsp_t host_rsp,
  input  wire sce_pkg::sce_chan_evt_t tx_done,
  output var  sce_pkg::sce_chan_evt_t tx_kick,
  output var  sce_pkg::sce_rx_post_t  rx_post,
  output var  logic                   ready
);
  import sce_pkg::*;

  localparam int AW = $clog2(NUM_TABLES);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef struct packed {
    sce_state_t          st;
    logic                rdy;
    logic [IDX_W-1:0]    init_idx;
    logic [IDX_W-1:0]    stack_top;
    logic [31:0]         cmd_word;
    logic [31:0]         ext_word;
    logic [4:0]          pending;
    sce_host_rsp_t       rsp;
    sce_chan_evt_t       kick;
    sce_rx_post_t        post;
    logic [NUM_TABLES-1:0] tx_active;
    logic [NUM_TABLES-1:0] rx_active;
  } sce_exec_state_t;

  sce_exec_state_t state_reg;
  sce_exec_state_t state_next;

  // Free-stack forward links and pool descriptors
  logic [IDX_W-1:0] fwd_link   [0:NUM_TABLES-1];
  logic [CNT_W-1:0] pool_count [0:NUM_POOLS-1];
  logic [31:0]      pool_addr  [0:NUM_POOLS-1];

  logic             fwd_we;
  logic [AW-1:0]    fwd_waddr;
  logic [IDX_W-1:0] fwd_wdata;
  logic             pool_we;
  logic [CNT_W-1:0] pool_wcount;
  logic [31:0]      pool_waddr;

  // --------------------------------------------------------------------
  // Queues and delay timer
  // --------------------------------------------------------------------
  logic        cmd_push_ready;
  logic        cmd_valid;
  logic        cmd_pop;
  logic [31:0] cmd_head;
  logic        ext_push_ready;
  logic        ext_valid;
  logic        ext_pop;
  logic [31:0] ext_head;
  logic        dly_start;
  logic        dly_busy;

  // Words arrive in host order and leave in that order
  sce_queue #(
    .WIDTH (32),
    .DEPTH (CMD_QUEUE_DEPTH)
  ) u_cmd_queue (
    .clk        (clk),
    .reset      (reset),
    .push_valid (host_req.cmd_wr),
    .push_ready (cmd_push_ready),
    .push_data  (host_req.wdata),
    .pop_valid  (cmd_valid),
    .pop_ready  (cmd_pop),
    .pop_data   (cmd_head)
  );

  sce_queue #(
    .WIDTH (32),
    .DEPTH (EXT_QUEUE_DEPTH)
  ) u_ext_queue (
    .clk        (clk),
    .reset      (reset),
    .push_valid (host_req.ext_wr),
    .push_ready (ext_push_ready),
    .push_data  (host_req.wdata),
    .pop_valid  (ext_valid),
    .pop_ready  (ext_pop),
    .pop_data   (ext_head)
  );

  sce_delay_timer #(
    .CYCLES (DELAY_CYCLES)
  ) u_delay (
    .clk   (clk),
    .reset (reset),
    .start (dly_start),
    .busy  (dly_busy)
  );

  // --------------------------------------------------------------------
  // Decode of the queued command
  // --------------------------------------------------------------------
  logic [3:0]        op;
  logic              sel_rx;
  logic [IDX_W-1:0]  idx;
  logic [AW-1:0]     idx_a;
  logic              idx_ok;
  logic [POOL_W-1:0] pool;
  logic [CNT_W-1:0]  cnt;
  logic              exec;
  logic              wr_indicating;

  assign op     = cmd_head[OP_HI:OP_LO];
  assign sel_rx = cmd_head[SEL_BIT];
  assign idx    = cmd_head[IDX_HI:IDX_LO];
  assign idx_a  = idx[AW-1:0];
  assign idx_ok = (idx != '0) && (idx < IDX_W'(NUM_TABLES));
  assign pool   = cmd_head[POOL_HI:POOL_LO];
  assign cnt    = cmd_head[CNT_HI:CNT_LO];

  // A refill waits for its extension word; a delay stalls every queued command
  assign exec = (state_reg.st == SCE_ST_RUN) && cmd_valid && !dly_busy &&
                ((op != OP_REFILL) || ext_valid);
  assign cmd_pop   = exec;
  assign ext_pop   = exec && (op == OP_REFILL);
  assign dly_start = exec && (op == OP_DELAY);

  // Only open and close return an indication
  assign wr_indicating = host_req.cmd_wr && cmd_push_ready &&
                         ((host_req.wdata[OP_HI:OP_LO] == OP_OPEN) ||
                          (host_req.wdata[OP_HI:OP_LO] == OP_CLOSE));

  assign host_rsp = state_reg.rsp;
  assign tx_kick  = state_reg.kick;
  assign rx_post  = state_reg.post;
  // Own flop, so the pin carries no decode of the state code
  assign ready    = state_reg.rdy;

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    logic             inc;
    logic             dec;
    logic             close_ok;
    logic [IDX_W-1:0] result;
    inc         = wr_indicating;
    dec         = 1'b0;
    close_ok    = 1'b0;
    result      = '0;
    state_next  = state_reg;
    fwd_we      = 1'b0;
    fwd_waddr   = '0;
    fwd_wdata   = '0;
    pool_we     = 1'b0;
    pool_wcount = '0;
    pool_waddr  = '0;
    state_next.kick.valid = 1'b0;
    state_next.post       = '0;
    state_next.rsp.rvalid = 1'b0;

    // Host port: command reads show the indication word with live busy
    if (host_req.cmd_rd) begin
      state_next.rsp.rvalid = 1'b1;
      state_next.rsp.rdata  = {state_reg.pending != '0, state_reg.cmd_word[BUSY_BIT-1:0]};
    end else if (host_req.ext_rd) begin
      state_next.rsp.rvalid = 1'b1;
      state_next.rsp.rdata  = state_reg.ext_word;
    end
    if (host_req.cmd_wr && cmd_push_ready) begin
      state_next.cmd_word = host_req.wdata;
    end
    if (host_req.ext_wr && ext_push_ready) begin
      state_next.ext_word = host_req.wdata;
    end

    // Descriptor with valid clear ends transmission
    if (tx_done.valid && (tx_done.idx < IDX_W'(NUM_TABLES))) begin
      state_next.tx_active[tx_done.idx[AW-1:0]] = 1'b0;
    end

    case (state_reg.st)
      SCE_ST_INIT: begin
        // Chain every table except index 0 into the free stack
        fwd_we    = 1'b1;
        fwd_waddr = state_reg.init_idx[AW-1:0];
        fwd_wdata = (state_reg.init_idx == IDX_W'(NUM_TABLES - 1)) ? '0 :
                    state_reg.init_idx + 1'b1;
        state_next.init_idx = state_reg.init_idx + 1'b1;
        if (state_reg.init_idx == IDX_W'(NUM_TABLES - 1)) begin
          state_next.stack_top = IDX_W'(1);
          state_next.st        = SCE_ST_RUN;
          state_next.rdy       = 1'b1;
        end
      end
      SCE_ST_RUN: begin
        if (exec) begin
          case (op)
            OP_OPEN: begin
              dec    = 1'b1;
              result = state_reg.stack_top;
              if (state_reg.stack_top != '0) begin
                state_next.stack_top = fwd_link[state_reg.stack_top[AW-1:0]];
              end
              state_next.cmd_word = {13'h0000, result, 4'h0};
            end
            OP_CLOSE: begin
              dec      = 1'b1;
              // Refuse a table still active on the selected side
              close_ok = idx_ok && !(sel_rx ? state_reg.rx_active[idx_a] :
                                              state_reg.tx_active[idx_a]);
              if (close_ok) begin
                fwd_we               = 1'b1;
                fwd_waddr            = idx_a;
                fwd_wdata            = state_reg.stack_top;
                state_next.stack_top = idx;
                result               = idx;
              end
              state_next.cmd_word = {13'h0000, result, 4'h0};
            end
            OP_DEACT: begin
              if (idx_ok) begin
                if (sel_rx) begin
                  state_next.rx_active[idx_a] = 1'b0;
                  state_next.post.valid  = 1'b1;
                  state_next.post.idx    = idx;
                  state_next.post.status = RX_DEACT_STATUS;
                end else begin
                  state_next.tx_active[idx_a] = 1'b0;
                end
              end
            end
            OP_TX_KICK: begin
              // Kick to a running channel leaves it alone
              if (idx_ok && !state_next.tx_active[idx_a]) begin
                state_next.tx_active[idx_a] = 1'b1;
                state_next.kick.valid       = 1'b1;
                state_next.kick.idx         = idx;
              end
            end
            OP_REFILL: begin
              pool_we = 1'b1;
              if (pool_count[pool] != '0) begin
                pool_wcount = pool_count[pool] + cnt;
                pool_waddr  = pool_addr[pool];
              end else begin
                pool_wcount = cnt;
                pool_waddr  = ext_head;
              end
            end
            default: begin
              // Delay and unknown opcodes change no table state
            end
          endcase
        end
      end
      default: begin
        state_next.st  = SCE_ST_INIT;
        state_next.rdy = 1'b0;
      end
    endcase

    // Set and clear cancel out when both land together
    state_next.pending     = state_reg.pending + {4'h0, inc} - {4'h0, dec};
    state_next.rsp.cmd_full = !cmd_push_ready;
    state_next.rsp.ext_full = !ext_push_ready;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg          <= '0;
      state_reg.st       <= SCE_ST_INIT;
      state_reg.cmd_word <= CMD_WORD_RESET;
      state_reg.ext_word <= EXT_WORD_RESET;
    end else begin
      state_reg <= state_next;
    end
    if (fwd_we) begin
      fwd_link[fwd_waddr] <= fwd_wdata;
    end
    // Pools start empty, so the first refill of each one loads it
    if (reset) begin
      for (int i = 0; i < NUM_POOLS; i++) begin
        pool_count[i] <= '0;
      end
    end else if (pool_we) begin
      pool_count[pool] <= pool_wcount;
      pool_addr[pool]  <= pool_waddr;
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic [6:0] since_delay;
  always_ff @(posedge clk) begin
    if (reset) begin
      since_delay <= 7'h7F;
    end else if (dly_start) begin
      since_delay <= 7'h00;
    end else if (since_delay != 7'h7F) begin
      since_delay <= since_delay + 7'h01;
    end
  end

  open_indication_a: assert property (exec && op == OP_OPEN |=>
    state_reg.cmd_word[IDX_HI:IDX_LO] == $past(state_reg.stack_top))
    else $error("open indication is not the old stack top");
  ind_low_zero_a: assert property (exec && (op == OP_OPEN || op == OP_CLOSE) |=>
    state_reg.cmd_word[3:0] == 4'h0 && state_reg.cmd_word[31:19] == '0)
    else $error("indication low nibble not zero");
  open_empty_a: assert property (exec && op == OP_OPEN && state_reg.stack_top == '0 |=>
    state_reg.cmd_word[IDX_HI:IDX_LO] == '0 && state_reg.stack_top == '0)
    else $error("open from empty stack gave a channel");
  close_push_a: assert property (exec && op == OP_CLOSE && idx_ok && !sel_rx &&
    !state_reg.tx_active[idx_a] |=> state_reg.stack_top == $past(idx) &&
    fwd_link[$past(idx_a)] == $past(state_reg.stack_top))
    else $error("closed table did not become stack top");
  close_reject_a: assert property (exec && op == OP_CLOSE && !idx_ok |=>
    state_reg.cmd_word[IDX_HI:IDX_LO] == '0)
    else $error("rejected close returned nonzero index");
  rx_deact_post_a: assert property (exec && op == OP_DEACT && sel_rx && idx_ok |=>
    rx_post.valid && rx_post.idx == $past(idx) && !state_reg.rx_active[$past(idx_a)]
    ##1 (rx_post.valid == $past(exec && op == OP_DEACT && sel_rx && idx_ok)))
    else $error("receive deactivate posted no indication");
  tx_kick_start_a: assert property (exec && op == OP_TX_KICK && idx_ok &&
    !state_reg.tx_active[idx_a] && !tx_done.valid |=> tx_kick.valid && state_reg.tx_active[$past(idx_a)])
    else $error("transmit kick did not start channel");
  tx_kick_ignore_a: assert property (exec && op == OP_TX_KICK && idx_ok &&
    state_reg.tx_active[idx_a] && !(tx_done.valid && tx_done.idx == idx) |=> !tx_kick.valid)
    else $error("kick to active channel was not ignored");
  refill_add_a: assert property (exec && op == OP_REFILL && pool_count[pool] != '0 |=>
    pool_count[$past(pool)] == $past(pool_count[pool]) + $past(cnt))
    else $error("refill did not add to remaining count");
  refill_load_a: assert property (exec && op == OP_REFILL && pool_count[pool] == '0 |=>
    pool_count[$past(pool)] == $past(cnt) && pool_addr[$past(pool)] == $past(ext_head))
    else $error("empty pool not loaded from refill");
  delay_hold_a: assert property (exec |-> since_delay >= 7'(DELAY_CYCLES))
    else $error("command ran inside delay window");
  busy_set_a: assert property (wr_indicating |=> state_reg.pending != '0)
    else $error("busy not set for indicating command");

endmodule

`default_nettype wire

// [tb/sce_host_model.sv]
// Host processor model: writes command and extension words, polls busy.
// Assumes the executor register port; each strobe lasts one cycle.
`timescale 1ns/1ps
`default_nettype none

module sce_host_model
  import sce_pkg::*;
(
  input  wire logic                   clk,
  output var  sce_pkg::sce_host_req_t req,
  input  wire sce_pkg::sce_host_rsp_t rsp
);
  initial req = '0;

  // Refill head goes to the extension word before its command
  task automatic wr(input logic c, input logic [31:0] d);
    @(posedge clk);
    req.cmd_wr <= c;
    req.ext_wr <= !c;
    req.wdata  <= d;
    @(posedge clk);
    req.cmd_wr <= 1'b0;
    req.ext_wr <= 1'b0;
    req.wdata  <= ~d;
  endtask

  // Indication is taken only once busy reads clear
  task automatic poll(input int max);
    for (int n = 0; n < max; n++) begin
      @(posedge clk);
      req.cmd_rd <= 1'b1;
      @(posedge clk);
      req.cmd_rd <= 1'b0;
      #1;
      if (rsp.rdata[31] === 1'b0) break;
    end
  endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the host command executor.
// Assumes eight channel tables so the free stack empties quickly.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import sce_pkg::*;
  localparam int NT = 8;
  logic          clk = 1'b0;
  logic          reset = 1'b1;
  sce_host_req_t host_req;
  sce_host_rsp_t host_rsp;
  sce_chan_evt_t tx_done = '0;
  sce_chan_evt_t tx_kick;
  sce_rx_post_t  rx_post;
  logic          ready;
  int            err_total = 0;
  int            check_count = 0;
  int            n;
  logic [31:0]   exp_rd[$];
  logic [31:0]   exp_ev[$];
  logic [4:0]    p;
  logic [15:0]   c;
  logic [31:0]   a;

  initial forever #4 clk = ~clk;

  sce_command_executor #(.NUM_TABLES(NT)) i_sce_command_executor (.clk(clk), .reset(reset),
    .host_req(host_req), .host_rsp(host_rsp), .tx_done(tx_done), .tx_kick(tx_kick),
    .rx_post(rx_post), .ready(ready));
  sce_host_model i_sce_host_model (.clk(clk), .req(host_req), .rsp(host_rsp));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  function automatic logic [31:0] cw(input logic [3:0] op, input logic s, input logic [14:0] i);
    return {2'b00, op, s, 6'h00, i, 4'h0};
  endfunction

  task automatic ind(input logic [31:0] w, input logic [14:0] e);
    exp_rd.push_back({13'h0000, e, 4'h0});
    i_sce_host_model.wr(1'b1, w);
    i_sce_host_model.poll(40);
  endtask

  task automatic kick(input logic [14:0] i, input logic fire);
    if (fire)
      exp_ev.push_back({17'h00000, i});
    i_sce_host_model.wr(1'b1, cw(OP_TX_KICK, 1'b0, i));
    repeat (4) @(posedge clk);
  endtask

  task automatic done_ev(input logic [14:0] i);
    @(posedge clk);
    tx_done <= '{valid: 1'b1, idx: i};
    @(posedge clk);
    tx_done <= '{valid: 1'b0, idx: ~i};
  endtask

  // Batches are taken as already chained and linked from the pool's tail
  task automatic refill(input logic [31:0] h, input logic [15:0] k);
    i_sce_host_model.wr(1'b0, h);
    i_sce_host_model.wr(1'b1, {2'b00, OP_REFILL, 5'h00, p, k});
    repeat (4) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Monitor: a busy-clear reply or pulse with nothing noted for it fails
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (host_rsp.rvalid === 1'b1 && host_rsp.rdata[31] === 1'b0)
      check(host_rsp.rdata, exp_rd.size() ? exp_rd.pop_front() : ~host_rsp.rdata);
    if (tx_kick.valid === 1'b1)
      check({17'h00000, tx_kick.idx}, exp_ev.size() ? exp_ev.pop_front() : 32'hFFFFFFFF);
    if (rx_post.valid === 1'b1)
      check({13'h0001, rx_post.idx, rx_post.status}, exp_ev.size() ? exp_ev.pop_front() : 32'h0);
  end

  // Roughly thirty times the expected run length
  initial begin
    #80000;
    err_total++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(35149));
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    n = 0;
    while (ready !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    check({31'h0, ready}, 32'h1);
    for (int i = 1; i < NT; i++)
      ind(cw(OP_OPEN, 1'b0, 15'h0), 15'(i));
    ind(cw(OP_OPEN, 1'b0, 15'h0), 15'h0);
    $display("test open done");
    kick(15'd3, 1'b1);
    kick(15'd3, 1'b0);
    exp_rd.push_back(cw(OP_TX_KICK, 1'b0, 15'd3));
    i_sce_host_model.poll(1);
    ind(cw(OP_CLOSE, 1'b0, 15'd3), 15'h0);
    done_ev(15'd3);
    kick(15'd3, 1'b1);
    i_sce_host_model.wr(1'b1, cw(OP_DEACT, 1'b0, 15'd3));
    kick(15'd3, 1'b1);
    done_ev(15'd3);
    ind(cw(OP_CLOSE, 1'b0, 15'd3), 15'd3);
    ind(cw(OP_OPEN, 1'b0, 15'h0), 15'd3);
    ind(cw(OP_CLOSE, 1'b1, 15'h0), 15'h0);
    $display("test transmit and close done");
    i_sce_host_model.wr(1'b1, cw(OP_DELAY, 1'b0, 15'h0));
    i_sce_host_model.wr(1'b1, cw(OP_DELAY, 1'b0, 15'h0));
    exp_ev.push_back({13'h0001, 15'd5, RX_DEACT_STATUS});
    i_sce_host_model.wr(1'b1, cw(OP_DEACT, 1'b1, 15'd5));
    repeat (90) @(posedge clk);
    exp_ev.push_back({17'h00000, 15'd4});
    i_sce_host_model.wr(1'b1, cw(OP_DELAY, 1'b0, 15'h0));
    i_sce_host_model.wr(1'b1, cw(OP_TX_KICK, 1'b0, 15'd4));
    n = 0;
    while (tx_kick.valid !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({31'h0, n >= 35 && n < 100}, 32'h1);
    i_sce_host_model.wr(1'b1, cw(OP_DELAY, 1'b0, 15'h0));
    repeat (10) i_sce_host_model.wr(1'b1, cw(OP_DEACT, 1'b0, 15'h0));
    @(posedge clk);
    #1;
    check({31'h0, host_rsp.cmd_full}, 32'h1);
    repeat (40) @(posedge clk);
    #1;
    check({31'h0, host_rsp.cmd_full}, 32'h0);
    $display("test delay done");
    p = 5'($urandom);
    c = 16'($urandom_range(1, 200));
    a = $urandom;
    refill(a, c);
    check(32'(i_sce_command_executor.pool_count[p]), 32'(c));
    check(32'(i_sce_command_executor.pool_addr[p]), a);
    refill(~a, 16'h0003);
    check(32'(i_sce_command_executor.pool_count[p]), 32'(c) + 32'h3);
    check(32'(i_sce_command_executor.pool_addr[p]), a);
    repeat (10) i_sce_host_model.wr(1'b0, $urandom);
    @(posedge clk);
    #1;
    check({31'h0, host_rsp.ext_full}, 32'h1);
    $display("test refill done");
    repeat (4) @(posedge clk);
    check(32'(exp_rd.size() + exp_ev.size()), 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
